/* include/fmsp_defines.vh */
// constants for the four mode serial port
`ifndef FMSP_DEFINES_VH
`define FMSP_DEFINES_VH
// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define FMSP_ADDR_CONTROL 8'h98
`define FMSP_ADDR_BUFFER 8'h99
`define FMSP_IRQ_VECTOR 8'h23
// ----------------------------------------------------------------
// serial_control field positions, reset value
// ----------------------------------------------------------------
`define FMSP_BIT_MODE_HIGH 7
`define FMSP_BIT_MODE_LOW 6
`define FMSP_BIT_MULTI_NODE 5
`define FMSP_BIT_RX_ENABLE 4
`define FMSP_BIT_TX_NINTH 3
`define FMSP_BIT_RX_NINTH 2
`define FMSP_BIT_TX_DONE 1
`define FMSP_BIT_RX_DONE 0
`define FMSP_CONTROL_RESET 8'h00
`define FMSP_BUFFER_RESET 8'h00
// ----------------------------------------------------------------
// modes
// ----------------------------------------------------------------
`define FMSP_MODE_SYNC 2'h0
`define FMSP_MODE_ASYNC8 2'h1
`define FMSP_MODE_ASYNC9_FIXED 2'h2
`define FMSP_MODE_ASYNC9_TIMER 2'h3
// ----------------------------------------------------------------
// timing: oscillator clocks (one clk_sys cycle each), oversample ticks per bit and tick indices, frame bit counts
// ----------------------------------------------------------------
`define FMSP_SYNC_CLK_PER_BIT 12
`define FMSP_SYNC_HALF 4'h6
`define FMSP_SYNC_LAST 4'hB
`define FMSP_FIXED_SLOW_CLK 64
`define FMSP_FIXED_FAST_CLK 32
`define FMSP_OVERSAMPLE 16
`define FMSP_TICK_MID 4'h7
`define FMSP_TICK_LAST 4'hF
`define FMSP_BITS_FRAME8 4'hA
`define FMSP_BITS_FRAME9 4'hB
// ----------------------------------------------------------------
// receive stream fifo
// ----------------------------------------------------------------
`define FMSP_FIFO_WIDTH 9
`define FMSP_FIFO_DEPTH 16
`define FMSP_FIFO_AW 4
`endif

/* logic/fmsp_serial_port.v */
// four mode serial port: fifo and port logic
`timescale 1ns/1ps
`default_nettype none
`include "fmsp_defines.vh"

// ----------------------------------------------------------------
// fifo of flip-flops, write and read by index
// ----------------------------------------------------------------
module fmsp_fifo #(
  parameter WIDTH = `FMSP_FIFO_WIDTH,
  parameter DEPTH = `FMSP_FIFO_DEPTH,
  parameter AW = `FMSP_FIFO_AW
) (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // filling side
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  // draining side
  output reg out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_push;
  wire do_pop;
  wire [AW:0] next_count;
  genvar i;

  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;
  assign next_count = count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
  assign out_data = mem[rd_ptr];

  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_entry
      localparam integer IDX = i;
      always @(posedge clk_sys)
      begin
        if (sys_rst)
          mem[i] <= {WIDTH{1'b0}};
        else if (do_push && wr_ptr == IDX[AW-1:0])
          mem[i] <= in_data;
      end
    end
  endgenerate

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= rd_ptr + 1'b1;
      count <= next_count;
      in_ready <= (next_count != DEPTH[AW:0]);
      out_valid <= (next_count != {(AW+1){1'b0}});
    end
  end
endmodule // fmsp_fifo

module fmsp_serial_port (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // special function register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  // baud sources and port latches
  input wire timer1_overflow,
  input wire fixed_rate_double,
  input wire port_latch_rx,
  input wire port_latch_tx,
  // pins
  input wire rxd_pin_in,
  output reg rxd_pin_out,
  output reg rxd_pin_oe_n,
  output reg txd_pin,
  // interrupt request
  output reg serial_irq,
  // received word stream, {ninth bit, data}
  output wire rx_stream_valid,
  input wire rx_stream_ready,
  output wire [8:0] rx_stream_data
);
  localparam RX_IDLE = 3'h0;
  localparam RX_START = 3'h1;
  localparam RX_DATA = 3'h2;
  localparam RX_STOP = 3'h3;
  localparam RX_DONE = 3'h4;

  // ----------------------------------------------------------------
  // registers and pin synchroniser
  // ----------------------------------------------------------------
  reg [7:0] serial_control;
  reg [7:0] rx_buffer;
  reg rxd_s1;
  reg rxd_s2;
  reg rx_line_d;
  wire rx_line;
  wire [1:0] mode;
  wire nine_bits;
  wire async_mode;
  wire ctl_wr;
  wire buf_wr;

  assign rx_line = rxd_s2 & port_latch_rx;
  assign mode = {serial_control[`FMSP_BIT_MODE_HIGH], serial_control[`FMSP_BIT_MODE_LOW]};
  assign nine_bits = mode[1];
  assign async_mode = (mode != `FMSP_MODE_SYNC);
  assign ctl_wr = sfr_wr && (sfr_addr == `FMSP_ADDR_CONTROL);
  assign buf_wr = sfr_wr && (sfr_addr == `FMSP_ADDR_BUFFER);

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      rx_line_d <= 1'b1;
    end
    else
    begin
      rxd_s1 <= rxd_pin_in;
      rxd_s2 <= rxd_s1;
      rx_line_d <= rx_line;
    end
  end

  // ----------------------------------------------------------------
  // oversample tick: timer 1 overflow or fixed divider
  // ----------------------------------------------------------------
  reg [5:0] fix_div;
  wire [5:0] fix_max;
  wire tick;

  localparam integer FIX_FAST = `FMSP_FIXED_FAST_CLK / `FMSP_OVERSAMPLE - 1;
  localparam integer FIX_SLOW = `FMSP_FIXED_SLOW_CLK / `FMSP_OVERSAMPLE - 1;

  // sixteen ticks per bit gives 32 or 64 clocks per bit in mode 2
  assign fix_max = fixed_rate_double ? FIX_FAST[5:0] : FIX_SLOW[5:0];
  assign tick = (mode == `FMSP_MODE_ASYNC9_FIXED) ? (fix_div == fix_max) :
    timer1_overflow;

  always @(posedge clk_sys)
  begin
    // a rate change can leave the divider above its new limit
    if (sys_rst || fix_div >= fix_max)
      fix_div <= 6'h00;
    else
      fix_div <= fix_div + 6'h01;
  end

  // ----------------------------------------------------------------
  // asynchronous receiver
  // ----------------------------------------------------------------
  reg [2:0] rx_state;
  reg [3:0] rx_tcnt;
  reg [3:0] rx_bcnt;
  reg [8:0] rx_sh;
  reg rx_stop;
  wire rx_ninth;
  wire [7:0] rx_word;
  wire rx_accept;
  wire rx_complete;
  wire fifo_in_ready;

  assign rx_ninth = nine_bits ? rx_sh[8] : rx_stop;
  assign rx_word = nine_bits ? rx_sh[7:0] : rx_sh[8:1];
  assign rx_accept = !(serial_control[`FMSP_BIT_MULTI_NODE] && !rx_ninth);
  // a full stream fifo holds the finished word back
  assign rx_complete = (rx_state == RX_DONE) &&
    (fifo_in_ready || !rx_accept);

  always @(posedge clk_sys)
  begin
    if (sys_rst || !async_mode || !serial_control[`FMSP_BIT_RX_ENABLE])
    begin
      rx_state <= RX_IDLE;
      rx_tcnt <= 4'h0;
      rx_bcnt <= 4'h0;
      rx_sh <= 9'h000;
      rx_stop <= 1'b0;
    end
    else
    begin
      if (tick)
        rx_tcnt <= rx_tcnt + 4'h1;
      case (rx_state)
        RX_IDLE:
        begin
          rx_tcnt <= 4'h0;
          rx_bcnt <= 4'h0;
          if (rx_line_d && !rx_line)
            rx_state <= RX_START;
        end
        RX_START:
          if (tick && rx_tcnt == `FMSP_TICK_MID)
          begin
            rx_tcnt <= 4'h0;
            rx_state <= rx_line ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (tick && rx_tcnt == `FMSP_TICK_LAST)
          begin
            rx_sh <= {rx_line, rx_sh[8:1]};
            rx_bcnt <= rx_bcnt + 4'h1;
            if (rx_bcnt == (nine_bits ? 4'h8 : 4'h7))
              rx_state <= RX_STOP;
          end
        RX_STOP:
          if (tick && rx_tcnt == `FMSP_TICK_LAST)
          begin
            rx_stop <= rx_line;
            rx_state <= RX_DONE;
          end
        RX_DONE:
          if (rx_complete)
            rx_state <= RX_IDLE;
        default:
          rx_state <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // asynchronous transmitter
  // ----------------------------------------------------------------
  reg tx_busy;
  reg [10:0] tx_sh;
  reg [3:0] tx_tcnt;
  reg [3:0] tx_left;
  wire tx_end;

  assign tx_end = tx_busy && tick && tx_tcnt == `FMSP_TICK_LAST &&
    tx_left == 4'h1;

  always @(posedge clk_sys)
  begin
    if (sys_rst || !async_mode)
    begin
      tx_busy <= 1'b0;
      tx_sh <= 11'h7FF;
      tx_tcnt <= 4'h0;
      tx_left <= 4'h0;
    end
    else if (buf_wr)
    begin
      // a write while busy restarts the frame
      tx_busy <= 1'b1;
      tx_tcnt <= 4'h0;
      tx_sh <= {1'b1, nine_bits ? serial_control[`FMSP_BIT_TX_NINTH] : 1'b1,
        sfr_wdata, 1'b0};
      tx_left <= nine_bits ? `FMSP_BITS_FRAME9 : `FMSP_BITS_FRAME8;
    end
    else if (tx_busy && tick)
    begin
      tx_tcnt <= tx_tcnt + 4'h1;
      if (tx_tcnt == `FMSP_TICK_LAST)
      begin
        tx_sh <= {1'b1, tx_sh[10:1]};
        tx_left <= tx_left - 4'h1;
        if (tx_left == 4'h1)
          tx_busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // synchronous shift engine, half duplex
  // ----------------------------------------------------------------
  reg m0_busy;
  reg m0_dir_rx;
  reg [3:0] m0_phase;
  reg [2:0] m0_bits;
  reg [7:0] m0_sh;
  reg m0_samp;
  wire m0_start_rx;
  wire m0_end;

  assign m0_start_rx = !async_mode && !m0_busy &&
    serial_control[`FMSP_BIT_RX_ENABLE] && !serial_control[`FMSP_BIT_RX_DONE];
  assign m0_end = m0_busy && m0_phase == `FMSP_SYNC_LAST &&
    m0_bits == 3'h7;

  always @(posedge clk_sys)
  begin
    if (sys_rst || async_mode)
    begin
      m0_busy <= 1'b0;
      m0_dir_rx <= 1'b0;
      m0_phase <= 4'h0;
      m0_bits <= 3'h0;
      m0_sh <= 8'h00;
      m0_samp <= 1'b0;
    end
    else if (buf_wr)
    begin
      m0_busy <= 1'b1;
      m0_dir_rx <= 1'b0;
      m0_phase <= 4'h0;
      m0_bits <= 3'h0;
      m0_sh <= sfr_wdata;
    end
    else if (m0_start_rx)
    begin
      m0_busy <= 1'b1;
      m0_dir_rx <= 1'b1;
      m0_phase <= 4'h0;
      m0_bits <= 3'h0;
    end
    else if (m0_busy)
    begin
      // sample at mid phase, as the shift clock rises; the far end shifts while it is low
      if (m0_phase == `FMSP_SYNC_HALF)
        m0_samp <= rx_line;
      if (m0_phase == `FMSP_SYNC_LAST)
      begin
        m0_phase <= 4'h0;
        m0_bits <= m0_bits + 3'h1;
        m0_sh <= m0_dir_rx ? {m0_samp, m0_sh[7:1]} :
          {1'b0, m0_sh[7:1]};
        if (m0_bits == 3'h7)
          m0_busy <= 1'b0;
      end
      else
        m0_phase <= m0_phase + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // receive stream fifo
  // ----------------------------------------------------------------
  wire fifo_push;

  assign fifo_push = rx_complete && rx_accept;

  fmsp_fifo #(
    .WIDTH(`FMSP_FIFO_WIDTH),
    .DEPTH(`FMSP_FIFO_DEPTH),
    .AW(`FMSP_FIFO_AW)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({rx_ninth, rx_word}),
    .out_valid(rx_stream_valid),
    .out_ready(rx_stream_ready),
    .out_data(rx_stream_data)
  );

  // ----------------------------------------------------------------
  // control register, receive buffer, read port
  // ----------------------------------------------------------------
  wire set_rx_done;
  wire set_tx_done;
  wire m0_rx_end;
  wire [7:0] next_serial_control;

  assign m0_rx_end = m0_end && m0_dir_rx;
  assign set_rx_done = fifo_push || m0_rx_end;
  assign set_tx_done = tx_end || (m0_end && !m0_dir_rx);
  // hardware set wins over a software clear in the same cycle
  assign next_serial_control = ctl_wr ? sfr_wdata : serial_control;

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      serial_control <= `FMSP_CONTROL_RESET;
      rx_buffer <= `FMSP_BUFFER_RESET;
      sfr_rdata <= 8'h00;
    end
    else
    begin
      serial_control[7:3] <= next_serial_control[7:3];
      serial_control[`FMSP_BIT_RX_NINTH] <= fifo_push ? rx_ninth :
        next_serial_control[`FMSP_BIT_RX_NINTH];
      serial_control[`FMSP_BIT_TX_DONE] <= next_serial_control[`FMSP_BIT_TX_DONE] |
        set_tx_done;
      serial_control[`FMSP_BIT_RX_DONE] <= next_serial_control[`FMSP_BIT_RX_DONE] |
        set_rx_done;
      if (fifo_push)
        rx_buffer <= rx_word;
      else if (m0_rx_end)
        rx_buffer <= {m0_samp, m0_sh[7:1]};
      if (sfr_rd && sfr_addr == `FMSP_ADDR_CONTROL)
        sfr_rdata <= serial_control;
      else if (sfr_rd && sfr_addr == `FMSP_ADDR_BUFFER)
        sfr_rdata <= rx_buffer;
      else
        sfr_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // pins and interrupt request
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      txd_pin <= 1'b0;
      rxd_pin_out <= 1'b1;
      rxd_pin_oe_n <= 1'b1;
      serial_irq <= 1'b0;
    end
    else
    begin
      if (async_mode)
        txd_pin <= port_latch_tx & (tx_busy ? tx_sh[0] : 1'b1);
      else
        txd_pin <= port_latch_tx &
          (!m0_busy || m0_phase >= `FMSP_SYNC_HALF);
      rxd_pin_out <= m0_sh[0];
      rxd_pin_oe_n <= !(port_latch_rx && m0_busy && !m0_dir_rx);
      serial_irq <= next_serial_control[`FMSP_BIT_TX_DONE] | set_tx_done |
        next_serial_control[`FMSP_BIT_RX_DONE] | set_rx_done;
    end
  end
endmodule // fmsp_serial_port
`default_nettype wire

/* tb/fmsp_chk_assertions.sv */
// checker on the serial port's ports
`timescale 1ns/1ps
`default_nettype none
`include "fmsp_defines.vh"
module fmsp_chk (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // register bus
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  // pins and stream
  input wire rxd_pin_oe_n,
  input wire txd_pin,
  input wire serial_irq,
  input wire rx_stream_valid,
  input wire rx_stream_ready,
  input wire [8:0] rx_stream_data
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  reg [7:0] ctl;
  reg [3:0] rises;
  wire to_buf = sfr_wr && sfr_addr == `FMSP_ADDR_BUFFER;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  always @(posedge clk_sys)
    if (sys_rst)
      ctl <= `FMSP_CONTROL_RESET;
    else if (sfr_wr && sfr_addr == `FMSP_ADDR_CONTROL)
      ctl <= sfr_wdata;
  // shift clock edges, counted only while the data pin is driven
  always @(posedge clk_sys)
    if (sys_rst || rxd_pin_oe_n)
      rises <= 4'h0;
    else if ($rose(txd_pin))
      rises <= rises + 4'h1;
  property p_quiet;
    !$past(sfr_rd) |-> sfr_rdata == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("read data without a read");
  property p_ctl_back;
    sfr_rd && !sfr_wr && sfr_addr == `FMSP_ADDR_CONTROL |=>
      ((sfr_rdata ^ $past(ctl)) & 8'hF8) == 8'h00;
  endproperty
  a_ctl_back: assert property (p_ctl_back)
    else $error("control bits differ from last write");
  property p_rst_idle;
    $fell(sys_rst) |-> rxd_pin_oe_n && !serial_irq && !rx_stream_valid;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("port not idle after reset");
  property p_tx_start;
    to_buf && ctl[7:6] != `FMSP_MODE_SYNC |=>
      ##1 (!txd_pin && rxd_pin_oe_n);
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("no start bit after buffer write");
  property p_sync_start;
    to_buf && ctl[7:6] == `FMSP_MODE_SYNC |=>
      ##1 (!txd_pin && !rxd_pin_oe_n);
  endproperty
  a_sync_start: assert property (p_sync_start)
    else $error("sync send did not take the data pin");
  property p_clk_low;
    $fell(txd_pin) && !rxd_pin_oe_n |-> (!txd_pin) [*6] ##1 txd_pin;
  endproperty
  a_clk_low: assert property (p_clk_low)
    else $error("shift clock low phase not six clocks");
  property p_pulses;
    $rose(rxd_pin_oe_n) |-> rises == 4'h8;
  endproperty
  a_pulses: assert property (p_pulses)
    else $error("shift clock pulse count not eight");
  property p_stall;
    rx_stream_valid && !rx_stream_ready |=>
      rx_stream_valid && $stable(rx_stream_data);
  endproperty
  a_stall: assert property (p_stall)
    else $error("stream head moved while stalled");
  c_sync: cover property ($rose(rxd_pin_oe_n));
  c_stall: cover property (rx_stream_valid && !rx_stream_ready);
  c_irq: cover property ($rose(serial_irq));
endmodule // fmsp_chk
bind fmsp_serial_port fmsp_chk u_chk (
  .clk_sys, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
  .sfr_rdata, .rxd_pin_oe_n, .txd_pin, .serial_irq, .rx_stream_valid,
  .rx_stream_ready, .rx_stream_data
);
`default_nettype wire

/* tb/fmsp_partner.sv */
// far side of the link: async frame sender and catcher
`timescale 1ns/1ps
`default_nettype none
module fmsp_partner #(
  parameter BIT_CLKS = 32
) (
  // clock
  input wire clk_sys,
  // link lines
  input wire txd_pin,
  input wire data_pin,
  output logic rxd_line
);
  // ----------------------------------------
  // frame tasks
  // ----------------------------------------
  // a released line rests at its pull-up level
  initial rxd_line = 1'b1;
  task automatic send(input logic [8:0] w, input int nb);
    int i;
    @(negedge clk_sys);
    rxd_line = 1'b0;
    repeat (BIT_CLKS) @(negedge clk_sys);
    for (i = 0; i < nb; i++)
    begin
      rxd_line = w[i];
      repeat (BIT_CLKS) @(negedge clk_sys);
    end
    rxd_line = 1'b1;
    repeat (BIT_CLKS) @(negedge clk_sys);
  endtask
  // samples mid bit; f[nb] holds the stop bit, all unknown on a hang
  task automatic grab(input int nb, output logic [9:0] f);
    int i, t;
    f = 10'h000;
    for (t = 0; t < 400 && txd_pin !== 1'b0; t++)
      @(negedge clk_sys);
    repeat (BIT_CLKS / 2) @(negedge clk_sys);
    for (i = 0; i <= nb; i++)
    begin
      repeat (BIT_CLKS) @(negedge clk_sys);
      f[i] = txd_pin;
    end
    if (t == 400)
      f = 10'hXXX;
  endtask
  // sync mode: take each bit on the port's rising shift clock
  task automatic sync_grab(output logic [7:0] d);
    int i, t;
    d = 8'h00;
    for (i = 0; i < 8; i++)
    begin
      for (t = 0; t < 30 && txd_pin !== 1'b0; t++)
        @(negedge clk_sys);
      for (t = 0; t < 30 && txd_pin !== 1'b1; t++)
        @(negedge clk_sys);
      d[i] = data_pin;
    end
  endtask
  // sync mode: new bit while the port's shift clock is low
  task automatic sync_send(input logic [7:0] d);
    int i, t;
    for (i = 0; i < 8; i++)
    begin
      for (t = 0; t < 30 && txd_pin !== 1'b0; t++)
        @(negedge clk_sys);
      rxd_line = d[i];
      for (t = 0; t < 30 && txd_pin !== 1'b1; t++)
        @(negedge clk_sys);
    end
    rxd_line = 1'b1;
  endtask
endmodule // fmsp_partner
`default_nettype wire

/* tb/fmsp_serial_port_bench.sv */
// self-checking bench for the four mode serial port
`timescale 1ns/1ps
`default_nettype none
`include "fmsp_defines.vh"
module fmsp_serial_port_bench;
  localparam logic [7:0] ctl_a = `FMSP_ADDR_CONTROL;
  localparam logic [7:0] buf_a = `FMSP_ADDR_BUFFER;
  logic clk_sys, sys_rst, sfr_wr, sfr_rd, tick, rx_ready;
  logic rate_double, latch_tx;
  logic [7:0] sfr_addr, sfr_wdata;
  wire [7:0] sfr_rdata;
  wire rxd_out, rxd_oe_n, txd_pin, serial_irq, rx_valid, rxd_line, rxd_pin;
  wire [8:0] rx_data;
  int n_mismatch = 0;
  int checks = 0;
  // the port owns the receive pin only while it sends in sync mode
  assign rxd_pin = rxd_oe_n ? rxd_line : rxd_out;
  fmsp_serial_port dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .timer1_overflow(tick),
    .fixed_rate_double(rate_double), .port_latch_rx(1'b1),
    .port_latch_tx(latch_tx),
    .rxd_pin_in(rxd_pin), .rxd_pin_out(rxd_out), .rxd_pin_oe_n(rxd_oe_n),
    .txd_pin(txd_pin), .serial_irq(serial_irq), .rx_stream_valid(rx_valid),
    .rx_stream_ready(rx_ready), .rx_stream_data(rx_data)
  );
  fmsp_partner #(.BIT_CLKS(32)) peer (
    .clk_sys(clk_sys), .txd_pin(txd_pin), .data_pin(rxd_pin),
    .rxd_line(rxd_line)
  );
  // ----------------------------------------
  // clock, bus tasks, scenarios
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // overflow every other clock: 16 ticks make a 32 clock bit
  always @(negedge clk_sys)
    tick <= ~tick;
  task automatic conclude;
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [9:0] got, input logic [9:0] e);
    checks++;
    if (got !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rchk(input logic [7:0] a, m, e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    check({2'h0, sfr_rdata & m}, {2'h0, e});
    @(negedge clk_sys);
  endtask
  task automatic wait_flag(input int idx);
    int n;
    for (n = 0; n < 500 && sfr_rdata[idx] !== 1'b1; n++)
    begin
      sfr_addr = ctl_a;
      sfr_rd = 1'b1;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      if (sfr_rdata[idx] !== 1'b1)
        @(negedge clk_sys);
    end
    if (sfr_rdata[idx] !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected at %0t: done flag never set", $time);
      conclude;
    end
    @(negedge clk_sys);
  endtask
  task automatic pop(input logic [9:0] e);
    check({rx_valid, rx_data}, e);
    rx_ready = 1'b1;
    @(negedge clk_sys);
    rx_ready = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic t_reset;
    rchk(ctl_a, 8'hFF, `FMSP_CONTROL_RESET);
    rchk(buf_a, 8'hFF, `FMSP_BUFFER_RESET);
    rchk(8'h97, 8'hFF, 8'h00);
    latch_tx = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({9'h000, txd_pin}, 10'h000);
    latch_tx = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic t_tx(input logic [7:0] c, d, input int nb,
    input logic [9:0] e);
    logic [9:0] f;
    wr(ctl_a, c);
    wr(buf_a, d);
    peer.grab(nb, f);
    check(f, e);
    wait_flag(`FMSP_BIT_TX_DONE);
    check({9'h000, serial_irq}, 10'h001);
    rchk(ctl_a, 8'hFB, c | 8'h02);
    wr(ctl_a, c);
    rchk(ctl_a, 8'hFB, c);
    check({9'h000, serial_irq}, 10'h000);
  endtask
  // slow mode 2: start and a zero bit keep the line low for 128 clocks
  task automatic t_slow;
    rate_double = 1'b0;
    wr(ctl_a, 8'h80);
    wr(buf_a, 8'hFE);
    repeat (100) @(negedge clk_sys);
    check({9'h000, txd_pin}, 10'h000);
    repeat (40) @(negedge clk_sys);
    check({9'h000, txd_pin}, 10'h001);
    wait_flag(`FMSP_BIT_TX_DONE);
    wr(ctl_a, 8'h00);
    rate_double = 1'b1;
  endtask
  task automatic t_rx;
    wr(ctl_a, 8'h50);
    peer.send(9'h03C, 8);
    peer.send(9'h0C3, 8);
    wait_flag(`FMSP_BIT_RX_DONE);
    rchk(buf_a, 8'hFF, 8'hC3);
    rchk(ctl_a, 8'hFF, 8'h55);
    pop(10'h33C);
    pop(10'h3C3);
    check({9'h000, rx_valid}, 10'h000);
    wr(ctl_a, 8'h50);
    rchk(ctl_a, 8'hFB, 8'h50);
  endtask
  task automatic t_filter;
    wr(ctl_a, 8'hF0);
    peer.send(9'h011, 9);
    repeat (2) @(negedge clk_sys);
    rchk(ctl_a, 8'hFB, 8'hF0);
    check({9'h000, rx_valid}, 10'h000);
    peer.send(9'h122, 9);
    wait_flag(`FMSP_BIT_RX_DONE);
    rchk(buf_a, 8'hFF, 8'h22);
    rchk(ctl_a, 8'hFF, 8'hF5);
    pop(10'h322);
  endtask
  task automatic t_sync;
    logic [7:0] d;
    wr(ctl_a, 8'h00);
    wr(buf_a, 8'h96);
    peer.sync_grab(d);
    check({2'h0, d}, 10'h096);
    wait_flag(`FMSP_BIT_TX_DONE);
    rchk(ctl_a, 8'hFB, 8'h02);
    check({9'h000, rxd_oe_n}, 10'h001);
    wr(ctl_a, 8'h10);
    peer.sync_send(8'h3A);
    wait_flag(`FMSP_BIT_RX_DONE);
    rchk(buf_a, 8'hFF, 8'h3A);
    rchk(ctl_a, 8'hFF, 8'h11);
    check({9'h000, rxd_oe_n}, 10'h001);
  endtask
  initial
  begin
    sys_rst = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    tick = 1'b0;
    rx_ready = 1'b0;
    rate_double = 1'b1;
    latch_tx = 1'b1;
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_reset;
    t_tx(8'h40, 8'hA5, 8, 10'h1A5);
    t_tx(8'h88, 8'h3C, 9, 10'h33C);
    t_tx(8'hC0, 8'h5A, 9, 10'h25A);
    t_slow;
    t_rx;
    t_filter;
    t_sync;
    conclude;
  end
endmodule // fmsp_serial_port_bench
`default_nettype wire
